// ===== psa_pkg.sv
// Package with register map, field layout and reset values of the PHY status and advertisement bank
package psa_pkg;

    // Byte offsets of the registers on the bus
    localparam logic [3:0] PSA_OFS_STATUS_FIRST = 4'h0;
    localparam logic [3:0] PSA_OFS_POLARITY = 4'h4;
    localparam logic [3:0] PSA_OFS_SPEED_DUPLEX = 4'h8;
    localparam logic [3:0] PSA_OFS_ADVERTISE = 4'hC;

    // First status register: fixed ability bits and live bits
    localparam logic [15:0] PSA_FIRST_FIXED = 16'h7809;
    localparam int PSA_FIRST_AN_DONE_BIT = 5;
    localparam int PSA_FIRST_LINK_BIT = 2;

    // Polarity status register layout
    localparam int PSA_POL_BIT = 4;
    localparam logic [15:0] PSA_POL_WMASK = 16'hFFE0;
    localparam logic [15:0] PSA_POL_RESET = 16'h0000;
    localparam logic [15:0] PSA_POL_LOW_READ = 16'h000B;

    // Speed and duplex status register layout
    localparam int PSA_SPD_LSB = 2;
    localparam logic [15:0] PSA_SPD_WMASK = 16'hFFE3;
    localparam logic [15:0] PSA_SPD_RESET = 16'h0040;

    // Speed and duplex codes
    localparam logic [2:0] PSA_SPD_100_FULL = 3'h6;
    localparam logic [2:0] PSA_SPD_100_HALF = 3'h2;
    localparam logic [2:0] PSA_SPD_10_FULL = 3'h5;
    localparam logic [2:0] PSA_SPD_10_HALF = 3'h1;

    // Advertisement register layout
    localparam int PSA_ADV_FAULT_BIT = 13;
    localparam logic [15:0] PSA_ADV_WMASK = 16'h2DFF;
    localparam logic [15:0] PSA_ADV_RESET = 16'h01E1;

    // Bus slave states
    typedef enum logic {
        PSA_BUS_IDLE = 1'b0,
        PSA_BUS_ACK = 1'b1
    } psa_bus_state_t;

endpackage

// ===== psa_wb_slave.sv
// Wishbone classic handshake: request strobe and single-cycle acknowledge
`timescale 1ns/1ns
module psa_wb_slave
    import psa_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    // Handshake
    output logic take_o,
    output logic ack_o
);

    psa_bus_state_t state_q;
    psa_bus_state_t state_d;

    // A request is taken once, in idle, and answered in the next cycle
    assign take_o = wb_cyc_i && wb_stb_i && (state_q == PSA_BUS_IDLE);
    assign state_d = take_o ? PSA_BUS_ACK : PSA_BUS_IDLE;
    assign ack_o = (state_q == PSA_BUS_ACK);

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= PSA_BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// ===== psa_link_status.sv
// Registered speed/duplex code and receive pair polarity from the PHY core
`timescale 1ns/1ns
module psa_link_status
    import psa_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // PHY core state
    input wire logic speed_100_i,
    input wire logic full_duplex_i,
    input wire logic rx_pair_reversed_raw_i,
    // Registered state
    output logic [2:0] speed_duplex_state_o,
    output logic rx_pair_reversed_o
);

    logic [2:0] code_d;
    logic rev_d;

    // Only the four defined codes can ever be produced
    assign code_d = speed_100_i ? (full_duplex_i ? PSA_SPD_100_FULL : PSA_SPD_100_HALF)
                                : (full_duplex_i ? PSA_SPD_10_FULL : PSA_SPD_10_HALF);
    // Polarity is meaningful in 10 Mbps operation only
    assign rev_d = rx_pair_reversed_raw_i && !speed_100_i;

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speed_duplex_state_o <= PSA_SPD_10_HALF;
            rx_pair_reversed_o <= 1'b0;
        end else begin
            speed_duplex_state_o <= code_d;
            rx_pair_reversed_o <= rev_d;
        end
    end

endmodule

// ===== psa_top.sv
// PHY status and auto-negotiation advertisement register bank on a Wishbone slave
`timescale 1ns/1ns
module psa_top
    import psa_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // PHY core state
    input wire logic speed_100_i,
    input wire logic full_duplex_i,
    input wire logic rx_pair_reversed_raw_i,
    input wire logic autoneg_done_i,
    input wire logic link_up_i,
    // PHY core control
    output logic rx_pair_swap_o,
    output logic [15:0] advertise_word_o,
    output logic advertise_remote_fault_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake

    logic take;
    logic ack_state;
    logic wr_en;
    logic [15:0] lane_mask;
    logic hit_first;
    logic hit_pol;
    logic hit_spd;
    logic hit_adv;

    psa_wb_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .take_o(take),
        .ack_o(ack_state)
    );

    // Address decode on all 32 address bits; anything else reads zero
    assign hit_first = (wb_adr_i[31:4] == 28'h000_0000) && (wb_adr_i[3:0] == PSA_OFS_STATUS_FIRST);
    assign hit_pol = (wb_adr_i[31:4] == 28'h000_0000) && (wb_adr_i[3:0] == PSA_OFS_POLARITY);
    assign hit_spd = (wb_adr_i[31:4] == 28'h000_0000) && (wb_adr_i[3:0] == PSA_OFS_SPEED_DUPLEX);
    assign hit_adv = (wb_adr_i[31:4] == 28'h000_0000) && (wb_adr_i[3:0] == PSA_OFS_ADVERTISE);
    // Writes land at the edge where the master sees ack, while the request is still held
    assign wr_en = ack_state && wb_cyc_i && wb_stb_i && wb_we_i;
    // Byte lanes 0 and 1 carry the 16-bit registers
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    ////////////////////////////////////////////////////////////////////////////
    // Link state from the PHY core

    logic [2:0] speed_duplex_state;
    logic rx_pair_reversed;

    psa_link_status u_link (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .speed_100_i(speed_100_i),
        .full_duplex_i(full_duplex_i),
        .rx_pair_reversed_raw_i(rx_pair_reversed_raw_i),
        .speed_duplex_state_o(speed_duplex_state),
        .rx_pair_reversed_o(rx_pair_reversed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [15:0] pol_q;
    logic [15:0] pol_d;
    logic [15:0] spd_q;
    logic [15:0] spd_d;
    logic [15:0] adv_q;
    logic [15:0] adv_d;
    logic [15:0] pol_wm;
    logic [15:0] spd_wm;
    logic [15:0] adv_wm;

    // Only writable bits on enabled lanes take the write data
    assign pol_wm = PSA_POL_WMASK & lane_mask;
    assign spd_wm = PSA_SPD_WMASK & lane_mask;
    assign adv_wm = PSA_ADV_WMASK & lane_mask;
    assign pol_d = (wr_en && hit_pol) ? ((pol_q & ~pol_wm) | (wb_dat_i[15:0] & pol_wm)) : pol_q;
    assign spd_d = (wr_en && hit_spd) ? ((spd_q & ~spd_wm) | (wb_dat_i[15:0] & spd_wm)) : spd_q;
    assign adv_d = (wr_en && hit_adv) ? ((adv_q & ~adv_wm) | (wb_dat_i[15:0] & adv_wm)) : adv_q;

    // Writable register bits; the reserved bit 6 of the speed register resets to 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pol_q <= PSA_POL_RESET;
            spd_q <= PSA_SPD_RESET;
            adv_q <= PSA_ADV_RESET;
        end else begin
            pol_q <= pol_d;
            spd_q <= spd_d;
            adv_q <= adv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read views

    logic [15:0] first_view;
    logic [15:0] pol_view;
    logic [15:0] spd_view;
    logic [15:0] adv_view;
    logic [15:0] rd_word;

    // Fixed ability bits are forced high, live bits come from the core
    assign first_view = PSA_FIRST_FIXED
                      | (16'(autoneg_done_i) << PSA_FIRST_AN_DONE_BIT)
                      | (16'(link_up_i) << PSA_FIRST_LINK_BIT);
    assign pol_view = (pol_q & PSA_POL_WMASK) | PSA_POL_LOW_READ
                    | (16'(rx_pair_reversed) << PSA_POL_BIT);
    assign spd_view = (spd_q & PSA_SPD_WMASK) | (16'(speed_duplex_state) << PSA_SPD_LSB);
    assign adv_view = adv_q & PSA_ADV_WMASK;
    assign rd_word = hit_first ? first_view :
                     hit_pol ? pol_view :
                     hit_spd ? spd_view :
                     hit_adv ? adv_view : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    logic [31:0] dat_d;

    // Read data is captured with a read request and held until the next read
    assign dat_d = (take && !wb_we_i) ? {16'h0000, rd_word} : wb_dat_o;

    // Bus answer and core control flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            rx_pair_swap_o <= 1'b0;
            advertise_word_o <= PSA_ADV_RESET;
            advertise_remote_fault_o <= 1'b0;
        end else begin
            wb_dat_o <= dat_d;
            wb_ack_o <= take;
            rx_pair_swap_o <= rx_pair_reversed;
            advertise_word_o <= adv_q & PSA_ADV_WMASK;
            advertise_remote_fault_o <= adv_q[PSA_ADV_FAULT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Reversed pair at 10 Mbps is swapped two cycles later
    a_pair_swap_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && rx_pair_reversed_raw_i && !speed_100_i) |=> ##1 rx_pair_swap_o)
        else $error("pair swap not applied");

    // No swap at 100 Mbps
    a_pair_swap_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        speed_100_i[*2] |=> !rx_pair_swap_o)
        else $error("pair swapped at 100 Mbps");

    // 100 Mbps full duplex reads code 110
    a_code_fast_full: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && speed_100_i && full_duplex_i) |=> (speed_duplex_state == 3'h6))
        else $error("wrong 100 full code");

    // Ten megabit half reads 001, and reserved codes never appear
    a_code_ten_half: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && !speed_100_i && !full_duplex_i) |=> (speed_duplex_state == 3'h1))
        else $error("wrong 10 half code");
    a_code_no_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        !(speed_duplex_state inside {3'h0, 3'h3, 3'h4, 3'h7}))
        else $error("reserved speed code");

    // Read of the first status register returns the fixed bits set
    a_fixed_ability_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && hit_first) |=> (wb_ack_o && ((wb_dat_o[15:0] & 16'h7809) == 16'h7809)))
        else $error("fixed ability bit read 0");

    // Remote fault write reaches the advertised output two cycles later
    a_fault_advertised: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_en && hit_adv && wb_sel_i[1]) |=> ##1 (advertise_remote_fault_o == $past(wb_dat_i[13], 2)))
        else $error("remote fault not advertised");

    // Ack is a single pulse one cycle after the request is taken
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single cycle");

endmodule

// ===== tb.sv
// Self-checking testbench for the PHY status and advertisement register bank
`timescale 1ns/1ns
module tb
    import psa_pkg::*;
;
    // Compare one value and count it
    `define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
        $display("ERROR %s expected %h seen %h", nm, exp, got); end end

    ////////////////////////////////////////////////////////////////////////////
    // Signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic speed_100_i = 1'b1;
    logic full_duplex_i = 1'b1;
    logic rx_pair_reversed_raw_i = 1'b0;
    logic autoneg_done_i = 1'b1;
    logic link_up_i = 1'b0;
    logic rx_pair_swap_o;
    logic [15:0] advertise_word_o;
    logic advertise_remote_fault_o;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] rd;

    // Clock at 10 MHz
    always #50 clk_i = ~clk_i;

    psa_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .speed_100_i(speed_100_i), .full_duplex_i(full_duplex_i), .rx_pair_reversed_raw_i(rx_pair_reversed_raw_i),
        .autoneg_done_i(autoneg_done_i), .link_up_i(link_up_i), .rx_pair_swap_o(rx_pair_swap_o),
        .advertise_word_o(advertise_word_o), .advertise_remote_fault_o(advertise_remote_fault_o));

    ////////////////////////////////////////////////////////////////////////////
    // Closing report
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; holds the request until ack is sampled high
    task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat, output logic [31:0] data);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'h3;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        data = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            $display("ERROR bus ack expected 1 seen timeout");
            give_verdict();
        end
    endtask

    // Let core inputs reach registers and outputs
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset_values();
        bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        `CHK("first fixed bits", 16'h7809, rd[15:0] & 16'h7809)
        `CHK("first live bits", 16'h0020, rd[15:0] & 16'h0024)
        // Swap the live inputs so both status bits are seen in each state
        @(posedge clk_i);
        autoneg_done_i <= 1'b0;
        link_up_i <= 1'b1;
        bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        `CHK("first live bits swapped", 16'h0004, rd[15:0] & 16'h0024)
        `CHK("first fixed bits again", 16'h7809, rd[15:0] & 16'h7809)
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        `CHK("polarity reset", 12'h000, rd[15:4])
        bus(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
        `CHK("speed bit6 reset", 1'b1, rd[6])
        bus(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        `CHK("advert reset", 16'h01E1, rd[15:0])
        `CHK("advert word reset", 16'h01E1, advertise_word_o)
        `CHK("fault out reset", 1'b0, advertise_remote_fault_o)
        bus(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
        `CHK("unmapped read", 32'h0000_0000, rd)
        $display("test reset values done");
    endtask

    task automatic test_speed_codes();
        logic [2:0] exp;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            speed_100_i <= i[1];
            full_duplex_i <= i[0];
            settle();
            exp = i[1] ? (i[0] ? 3'b110 : 3'b010) : (i[0] ? 3'b101 : 3'b001);
            bus(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
            `CHK("speed code", exp, rd[4:2])
        end
        // Software keeps bit 6 at 1 and other reserved bits at 0 when writing
        bus(1'b1, 32'h0000_0008, 32'h0000_0040, rd);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
        `CHK("speed code after write", 3'b110, rd[4:2])
        `CHK("speed bit6 after write", 1'b1, rd[6])
        $display("test speed codes done");
    endtask

    task automatic test_polarity();
        logic [2:0] cfg [3] = '{3'b010, 3'b110, 3'b000};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            speed_100_i <= cfg[i][2];
            rx_pair_reversed_raw_i <= cfg[i][1];
            settle();
            bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
            `CHK("polarity flag", cfg[i][1] & ~cfg[i][2], rd[4])
            `CHK("pair swap", cfg[i][1] & ~cfg[i][2], rx_pair_swap_o)
        end
        // Reserved storage bits stay written as 0
        bus(1'b1, 32'h0000_0004, 32'h0000_0000, rd);
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        `CHK("polarity upper", 11'h000, rd[15:5])
        $display("test polarity done");
    endtask

    task automatic test_remote_fault();
        bus(1'b1, 32'h0000_000C, 32'h0000_E1E1, rd);
        bus(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        `CHK("advert with fault", 16'h21E1, rd[15:0])
        settle();
        `CHK("fault out set", 1'b1, advertise_remote_fault_o)
        `CHK("advert word set", 16'h21E1, advertise_word_o)
        bus(1'b1, 32'h0000_000C, 32'h0000_01E1, rd);
        settle();
        `CHK("fault out clear", 1'b0, advertise_remote_fault_o)
        bus(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        `CHK("advert cleared", 16'h01E1, rd[15:0])
        $display("test remote fault done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        test_reset_values();
        test_speed_codes();
        test_polarity();
        test_remote_fault();
        give_verdict();
    end
endmodule
